// ==== urx_pkg.sv ====
// Package with constants for the receiver data recovery block
package urx_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_VERIFY_A = 4'h2;
  localparam logic [3:0] TICK_VERIFY_B = 4'h4;
  localparam logic [3:0] TICK_VERIFY_C = 4'h6;
  localparam logic [3:0] TICK_VOTE_A = 4'h7;
  localparam logic [3:0] TICK_VOTE_B = 4'h8;
  localparam logic [3:0] TICK_VOTE_C = 4'h9;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [3:0] IDLE_EIGHT = 4'hA;
  localparam logic [3:0] IDLE_NINE = 4'hB;
  localparam logic [8:0] DATA_RESET = 9'h000;
  localparam logic [2:0] LINE_RESET = 3'h7;
  typedef enum logic [1:0] {
    URX_HUNT,
    URX_START,
    URX_DATA,
    URX_STOP
  } urx_state_type;
endpackage

// ==== urx_sync.sv ====
// Three-stage input synchroniser with agreement filter
module urx_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);
  logic [2:0] stage;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage <= urx_pkg::LINE_RESET;
    end else begin
      stage <= {stage[1:0], pin};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      level <= 1'b1;
    end else if (stage[1] == stage[2]) begin
      level <= stage[2];
    end
  end
endmodule

// ==== urx_recovery.sv ====
// Receiver data recovery: start search, majority vote, flags and wakeup
module urx_recovery (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial line and oversample tick
  input wire logic serial_input_pin,
  input wire logic oversample_tick,
  // Configuration
  input wire logic nine_bit_mode,
  input wire logic wake_address_mark,
  input wire logic idle_count_origin,
  input wire logic receiver_enable,
  // Standby control
  input wire logic standby_set,
  // Software flag clears
  input wire logic clear_receive_full,
  input wire logic clear_idle,
  input wire logic clear_errors,
  // Received data and status
  output logic [8:0] serial_data_buffer,
  output logic receive_full_flag,
  output logic idle_flag,
  output logic noise_flag,
  output logic framing_error_flag,
  output logic standby_request,
  output logic receive_irq
);
  urx_pkg::urx_state_type state;
  logic line;
  logic [3:0] tick;
  logic [3:0] bit_index;
  logic [2:0] history;
  logic [2:0] votes;
  logic [8:0] shift;
  logic early_fall;
  logic bit_end;
  logic [3:0] hunt_tick;
  logic char_noise;
  logic [3:0] idle_count;
  logic idle_armed;
  logic tick_vote_c;
  logic voted;
  logic disagree;
  logic [3:0] bit_count;
  logic [3:0] idle_limit;
  logic char_done;
  logic [8:0] next_data;
  logic stop_bad;
  logic noise_done;
  logic idle_seen;
  logic idle_wake;

  function automatic logic majority(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic mixed(input logic [2:0] s);
    return (s != 3'h0) && (s != 3'h7);
  endfunction

  urx_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin(serial_input_pin),
    .level(line)
  );

  always_comb begin
    bit_count = nine_bit_mode ? urx_pkg::BITS_NINE : urx_pkg::BITS_EIGHT;
    idle_limit = nine_bit_mode ? urx_pkg::IDLE_NINE : urx_pkg::IDLE_EIGHT;
    tick_vote_c = oversample_tick && tick == urx_pkg::TICK_VOTE_C;
    voted = majority({votes[1:0], line});
    disagree = mixed({votes[1:0], line});
    stop_bad = !voted;
    char_done = state == urx_pkg::URX_STOP && tick_vote_c;
    next_data = nine_bit_mode ? shift : {1'b0, shift[8:1]};
    noise_done = char_noise | disagree;
    early_fall = state == urx_pkg::URX_DATA && tick > urx_pkg::TICK_VOTE_C && majority(votes)
                 && history[0] && !line;
    bit_end = oversample_tick && state == urx_pkg::URX_DATA
              && (tick == urx_pkg::TICK_LAST || early_fall);
    idle_seen = oversample_tick && hunt_tick == urx_pkg::TICK_LAST && line
                && state == urx_pkg::URX_HUNT && idle_count == idle_limit - 4'h1;
    idle_wake = idle_seen && idle_armed && standby_request && !wake_address_mark;
  end

  // Bit sampling state machine
  always_ff @(posedge core_clk) begin
    if (rst || !receiver_enable) begin
      state <= urx_pkg::URX_HUNT;
      tick <= 4'h0;
      bit_index <= 4'h0;
      history <= urx_pkg::LINE_RESET;
      votes <= 3'h0;
      shift <= urx_pkg::DATA_RESET;
      char_noise <= 1'b0;
    end else if (oversample_tick) begin
      history <= {history[1:0], line};
      case (state)
        urx_pkg::URX_HUNT: begin
          tick <= 4'h0;
          if (history == 3'h7 && !line) begin
            state <= urx_pkg::URX_START;
            tick <= 4'h1;
            votes <= 3'h0;
            char_noise <= 1'b0;
          end
        end
        urx_pkg::URX_START: begin
          tick <= tick + 4'h1;
          if (tick == urx_pkg::TICK_VERIFY_A || tick == urx_pkg::TICK_VERIFY_B
              || tick == urx_pkg::TICK_VERIFY_C || tick == urx_pkg::TICK_VOTE_A
              || tick == urx_pkg::TICK_VOTE_B) begin
            votes <= {votes[1:0], line};
          end
          if (tick == urx_pkg::TICK_VERIFY_C) begin
            if (majority({votes[1:0], line})) begin
              state <= urx_pkg::URX_HUNT;
              tick <= 4'h0;
            end else begin
              char_noise <= mixed({votes[1:0], line});
              votes <= 3'h0;
            end
          end
          if (tick == urx_pkg::TICK_VOTE_C) begin
            char_noise <= char_noise | (votes[1:0] != 2'h0) | line;
          end
          if (tick == urx_pkg::TICK_LAST) begin
            state <= urx_pkg::URX_DATA;
            tick <= 4'h0;
            bit_index <= 4'h0;
          end
        end
        default: begin
          tick <= tick + 4'h1;
          if (tick == urx_pkg::TICK_VOTE_A || tick == urx_pkg::TICK_VOTE_B) begin
            votes <= {votes[1:0], line};
          end
          if (tick == urx_pkg::TICK_VOTE_C) begin
            votes <= {votes[1:0], line};
          end
          if (early_fall) begin
            tick <= 4'h1;
          end
          if (bit_end) begin
            bit_index <= bit_index + 4'h1;
            shift <= {majority(votes), shift[8:1]};
            char_noise <= char_noise | mixed(votes);
            if (bit_index == bit_count - 4'h1) begin
              state <= urx_pkg::URX_STOP;
            end
          end
          if (state == urx_pkg::URX_STOP && tick == urx_pkg::TICK_VOTE_C) begin
            state <= urx_pkg::URX_HUNT;
            tick <= 4'h0;
            history <= {3{line}};
          end
        end
      endcase
    end
  end

  // Data buffer, receive full and error flags
  always_ff @(posedge core_clk) begin
    if (rst) begin
      serial_data_buffer <= urx_pkg::DATA_RESET;
      receive_full_flag <= 1'b0;
      noise_flag <= 1'b0;
      framing_error_flag <= 1'b0;
    end else begin
      if (clear_receive_full) begin
        receive_full_flag <= 1'b0;
      end
      if (clear_errors) begin
        noise_flag <= 1'b0;
        framing_error_flag <= 1'b0;
      end
      if (char_done && receiver_enable
          && (!standby_request || (wake_address_mark && next_data[bit_count - 4'h1]))) begin
        serial_data_buffer <= next_data;
        receive_full_flag <= 1'b1;
        framing_error_flag <= stop_bad;
        noise_flag <= noise_done;
      end
    end
  end

  // Idle detection counter
  always_ff @(posedge core_clk) begin
    if (rst || !receiver_enable) begin
      idle_count <= 4'h0;
      idle_armed <= 1'b1;
      idle_flag <= 1'b0;
    end else begin
      if (clear_idle) begin
        idle_flag <= 1'b0;
      end
      if (state == urx_pkg::URX_START && oversample_tick && tick == urx_pkg::TICK_LAST) begin
        idle_count <= 4'h0;
        idle_armed <= 1'b1;
      end else if (bit_end) begin
        idle_count <= (majority(votes) && !idle_count_origin) ? idle_count + 4'h1 : 4'h0;
      end else if (char_done) begin
        idle_count <= (voted && !idle_count_origin) ? idle_count + 4'h1 : 4'h0;
      end else if (idle_seen) begin
        idle_count <= 4'h0;
        idle_armed <= 1'b0;
        if (idle_armed && !idle_wake && !standby_request) begin
          idle_flag <= 1'b1;
        end
      end else if (state == urx_pkg::URX_HUNT && oversample_tick && line
                   && hunt_tick == urx_pkg::TICK_LAST) begin
        idle_count <= idle_count + 4'h1;
      end else if (state == urx_pkg::URX_HUNT && !line) begin
        idle_count <= 4'h0;
      end
    end
  end

  // Sub-bit counter in hunt state for idle bit times
  always_ff @(posedge core_clk) begin
    if (rst || state != urx_pkg::URX_HUNT || !line) begin
      hunt_tick <= 4'h0;
    end else if (oversample_tick) begin
      hunt_tick <= hunt_tick + 4'h1;
    end
  end

  // Standby request and wakeup
  always_ff @(posedge core_clk) begin
    if (rst) begin
      standby_request <= 1'b0;
    end else if (standby_set) begin
      standby_request <= 1'b1;
    end else if (idle_wake) begin
      standby_request <= 1'b0;
    end else if (char_done && wake_address_mark && next_data[bit_count - 4'h1]) begin
      standby_request <= 1'b0;
    end
  end

  // Receiver interrupt request gated by standby
  always_ff @(posedge core_clk) begin
    if (rst) begin
      receive_irq <= 1'b0;
    end else begin
      receive_irq <= !standby_request && (receive_full_flag || idle_flag);
    end
  end
endmodule

// ==== urx_tx_model.sv ====
// Serial transmitter model driving the receive line
module urx_tx_model (
  // Clock and tick
  input wire logic core_clk,
  input wire logic oversample_tick,
  // Serial line
  output logic serial_input_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_ticks = 16;
  initial serial_input_pin = 1'b1;
  task automatic tick_wait(input int n);
    repeat (n) @(posedge core_clk iff oversample_tick);
  endtask
  // Start, data lsb first, stop; each bit lasts bit_ticks ticks
  task automatic send(input logic nine, input logic [8:0] d, input logic stop, input logic noisy);
    logic [10:0] f;
    f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    tick_wait(4);
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      for (int t = 0; t < bit_ticks; t++) begin
        #5 serial_input_pin = f[i] ^ (noisy && i == 1 && t == 8);
        tick_wait(1);
      end
    end
    #5 serial_input_pin = 1'b1;
  endtask
  // Short low pulse that start verification must reject
  task automatic glitch();
    tick_wait(4);
    #5 serial_input_pin = 1'b0;
    tick_wait(2);
    #5 serial_input_pin = 1'b1;
  endtask
endmodule

// ==== urx_recovery_checker.sv ====
// Concurrent checks on the receiver data recovery ports
module urx_recovery_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Watched inputs
  input wire logic oversample_tick,
  input wire logic wake_address_mark,
  // Watched outputs
  input wire logic [8:0] serial_data_buffer,
  input wire logic receive_full_flag,
  input wire logic idle_flag,
  input wire logic noise_flag,
  input wire logic framing_error_flag,
  input wire logic standby_request,
  input wire logic receive_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence rx_done;
    $rose(receive_full_flag) && $past(oversample_tick);
  endsequence
  sequence woke;
    $fell(standby_request) && !$past(rst);
  endsequence
  full_on_tick_a: assert property ($rose(receive_full_flag) |-> rx_done)
    else $error("receive full rose off a sample tick");
  irq_raise_a: assert property (rx_done ##0 !standby_request |=> receive_irq)
    else $error("no interrupt after receive full");
  standby_mute_a: assert property (standby_request |=> !receive_irq)
    else $error("interrupt raised in standby");
  fe_with_full_a: assert property ($rose(framing_error_flag)
    |-> receive_full_flag && $past(oversample_tick))
    else $error("framing error not set with receive full");
  noise_on_tick_a: assert property ($rose(noise_flag) |-> $past(oversample_tick))
    else $error("noise flag rose off a sample tick");
  idle_on_tick_a: assert property ($rose(idle_flag) |-> $past(oversample_tick))
    else $error("idle flag rose off a sample tick");
  mark_wake_a: assert property (woke ##0 wake_address_mark |-> ##[0:1] receive_full_flag)
    else $error("address mark wake without receive full");
  idle_wake_a: assert property (woke ##0 !wake_address_mark
    |-> !$rose(idle_flag) && !$rose(receive_full_flag))
    else $error("idle wake set a flag");
  buf_load_a: assert property ($changed(serial_data_buffer) && !$past(rst)
    |-> receive_full_flag && $past(oversample_tick))
    else $error("buffer changed without receive full");
endmodule
bind urx_recovery urx_recovery_checker u_urx_recovery_checker (
  .core_clk(core_clk),
  .rst(rst),
  .oversample_tick(oversample_tick),
  .wake_address_mark(wake_address_mark),
  .serial_data_buffer(serial_data_buffer),
  .receive_full_flag(receive_full_flag),
  .idle_flag(idle_flag),
  .noise_flag(noise_flag),
  .framing_error_flag(framing_error_flag),
  .standby_request(standby_request),
  .receive_irq(receive_irq)
);

// ==== urx_recovery_tb.sv ====
// Testbench for the receiver data recovery block
module urx_recovery_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic nine;
    logic [8:0] data;
    logic stop;
    logic noisy;
    logic fe;
    logic nf;
  } urx_row_type;
  logic core_clk = 1'b0;
  logic rst, oversample_tick, nine_bit_mode, wake_address_mark, idle_count_origin;
  logic standby_set, clear_receive_full, clear_idle, clear_errors, serial_input_pin;
  logic [8:0] serial_data_buffer;
  logic receive_full_flag, idle_flag, noise_flag, framing_error_flag, standby_request;
  logic receive_irq;
  logic [1:0] tick_div = 2'h0;
  int num_errors = 0;
  int check_count = 0;
  urx_row_type rows [6] = '{
    '{1'h0, 9'h0A5, 1'h1, 1'h0, 1'h0, 1'h0},
    '{1'h1, 9'h1C3, 1'h1, 1'h0, 1'h0, 1'h0},
    '{1'h0, 9'h03C, 1'h1, 1'h1, 1'h0, 1'h1},
    '{1'h0, 9'h000, 1'h0, 1'h0, 1'h1, 1'h0},
    '{1'h0, 9'h055, 1'h0, 1'h0, 1'h1, 1'h0},
    '{1'h0, 9'h0F0, 1'h1, 1'h0, 1'h0, 1'h0}
  };
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    #5 tick_div = tick_div + 2'h1;
  end
  assign oversample_tick = (tick_div == 2'h3);
  urx_tx_model u_urx_tx_model (.core_clk(core_clk), .oversample_tick(oversample_tick),
    .serial_input_pin(serial_input_pin));
  urx_recovery u_urx_recovery (.core_clk(core_clk), .rst(rst),
    .serial_input_pin(serial_input_pin), .oversample_tick(oversample_tick),
    .nine_bit_mode(nine_bit_mode), .wake_address_mark(wake_address_mark),
    .idle_count_origin(idle_count_origin), .receiver_enable(1'b1),
    .standby_set(standby_set), .clear_receive_full(clear_receive_full),
    .clear_idle(clear_idle), .clear_errors(clear_errors),
    .serial_data_buffer(serial_data_buffer), .receive_full_flag(receive_full_flag),
    .idle_flag(idle_flag), .noise_flag(noise_flag), .framing_error_flag(framing_error_flag),
    .standby_request(standby_request), .receive_irq(receive_irq));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(input logic [3:0] p);
    @(posedge core_clk);
    #5 {standby_set, clear_receive_full, clear_idle, clear_errors} = p;
    @(posedge core_clk);
    #5 {standby_set, clear_receive_full, clear_idle, clear_errors} = 4'h0;
  endtask
  task automatic bits_wait(input int n);
    repeat (n * 64) @(posedge core_clk);
  endtask
  task automatic conclude();
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {rst, nine_bit_mode, wake_address_mark, idle_count_origin} = 4'h8;
    {standby_set, clear_receive_full, clear_idle, clear_errors} = 4'h0;
    repeat (20) @(posedge core_clk);
    #5 rst = 1'b0;
    check({standby_request, receive_full_flag, idle_flag, noise_flag}, 9'h000);
    check(serial_data_buffer, 9'h000);
    foreach (rows[i]) begin
      nine_bit_mode = rows[i].nine;
      pulse(4'h7);
      u_urx_tx_model.send(rows[i].nine, rows[i].data, rows[i].stop, rows[i].noisy);
      check(serial_data_buffer, rows[i].nine ? rows[i].data : {1'h0, rows[i].data[7:0]});
      check(receive_full_flag, 1'h1);
      check(framing_error_flag, rows[i].fe);
      check(noise_flag, rows[i].nf);
    end
    pulse(4'h4);
    bits_wait(12);
    check({idle_flag, receive_irq}, 9'h003);
    pulse(4'h7);
    u_urx_tx_model.glitch();
    bits_wait(11);
    check(receive_full_flag, 1'h0);
    u_urx_tx_model.send(1'h0, 9'h05A, 1'h1, 1'h0);
    check(serial_data_buffer, 9'h05A);
    u_urx_tx_model.bit_ticks = 15;
    pulse(4'h7);
    u_urx_tx_model.send(1'h0, 9'h055, 1'h1, 1'h0);
    u_urx_tx_model.bit_ticks = 16;
    check(serial_data_buffer, 9'h055);
    check({framing_error_flag, noise_flag}, 9'h000);
    wake_address_mark = 1'h1;
    pulse(4'hF);
    u_urx_tx_model.send(1'h0, 9'h012, 1'h1, 1'h0);
    check({standby_request, receive_full_flag, receive_irq}, 9'h004);
    u_urx_tx_model.send(1'h0, 9'h092, 1'h1, 1'h0);
    check({standby_request, receive_full_flag}, 9'h001);
    check(serial_data_buffer, 9'h092);
    wake_address_mark = 1'h0;
    idle_count_origin = 1'h1;
    pulse(4'h7);
    fork
      u_urx_tx_model.send(1'h0, 9'h033, 1'h1, 1'h0);
      begin
        bits_wait(3);
        pulse(4'h8);
      end
    join
    bits_wait(12);
    check({standby_request, receive_full_flag, idle_flag}, 9'h000);
    conclude();
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    num_errors++;
    conclude();
  end
endmodule
